/* pkg/rcs_pkg.sv */
// Constants and types shared by the reset cause and initial state logic
package rcs_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] RCS_OFF_STATUS = 8'h00;
  localparam logic [7:0] RCS_OFF_WDT_CTRL = 8'h04;
  localparam logic [7:0] RCS_OFF_LVL_SEL = 8'h08;
  localparam logic [7:0] RCS_OFF_PORT_DIR = 8'h0c;
  localparam logic [7:0] RCS_OFF_RST_FLAGS = 8'h10;
  localparam logic [7:0] RCS_OFF_CAUSE = 8'h14;
  localparam logic [7:0] RCS_OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] RCS_OFF_IRQ_CLR = 8'h1c;
  localparam logic [7:0] RCS_OFF_IRQ_EN = 8'h20;

  // ****************************************
  // Initial values
  // ****************************************
  localparam logic [7:0] RCS_WDT_CTRL_INIT = 8'h53;
  localparam logic [7:0] RCS_LVL_SEL_INIT = 8'h55;
  localparam logic [7:0] RCS_PORT_DIR_INIT = 8'hff;

  // ****************************************
  // Field layouts and codes
  // ****************************************
  localparam int RCS_WEN_MSB = 7;
  localparam int RCS_WEN_LSB = 3;
  localparam logic [4:0] RCS_WEN_ENABLE = 5'h0a;
  localparam logic [4:0] RCS_WEN_DISABLE = 5'h15;
  localparam logic [7:0] RCS_LVL_CODE_0 = 8'h55;
  localparam logic [7:0] RCS_LVL_CODE_1 = 8'h33;
  localparam logic [7:0] RCS_LVL_CODE_2 = 8'h99;
  localparam logic [7:0] RCS_LVL_CODE_3 = 8'haa;

  localparam int RCS_ST_TIMEOUT = 0;
  localparam int RCS_ST_POWERDOWN = 1;
  localparam int RCS_FL_WDT_SW = 0;
  localparam int RCS_FL_LVL_SW = 1;
  localparam int RCS_FL_BROWNOUT = 2;
  localparam int RCS_NUM_FLAGS = 3;

  localparam int RCS_EV_POR = 0;
  localparam int RCS_EV_BROWNOUT = 1;
  localparam int RCS_EV_WDT_RUN = 2;
  localparam int RCS_EV_WDT_SLEEP = 3;
  localparam int RCS_EV_SW_RESET = 4;
  localparam int RCS_NUM_EVENTS = 5;

  // ****************************************
  // Timing
  // ****************************************
  // Slow rises counted before the invalid-code reset; it fires on the next rise.
  // The first rise may come at once, so the delay lands between 2 and 3 periods.
  localparam logic [1:0] RCS_SW_RST_LOW_SPEED_INTERNAL_OSC_CYC = 2'h2;

  // ****************************************
  // Reset cause selector
  // ****************************************
  typedef enum logic [4:0] {
    RCS_CAUSE_NONE = 5'b00001,
    RCS_CAUSE_POR = 5'b00010,
    RCS_CAUSE_BROWNOUT = 5'b00100,
    RCS_CAUSE_WDT_RUN = 5'b01000,
    RCS_CAUSE_WDT_SLEEP = 5'b10000
  } rcs_cause_t;

endpackage

/* logic/rcs_sync3.sv */
// Three-stage synchroniser; output follows once the last two stages agree
`timescale 1ns/1ps
`default_nettype none
module rcs_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] lvl_reg;
  logic [WIDTH-1:0] lvl_next;

  // Stage one feeds stage two only
  always_comb begin
    lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign o_level = lvl_reg;

endmodule // rcs_sync3
`default_nettype wire

/* logic/rcs_reset_seq.sv */
// Reset cause resolution, status flags and initial register values
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] Running watchdog expiry acts like brown-out, but sets the time-out flag.
// [R2] Sleeping watchdog expiry clears program counter and stack pointer, sets time-out.
// [R3] Power-on reset clears time-out and power-down flags.
// [R4] Brown-out reset keeps both flags unchanged.
// [R5] Running watchdog reset sets time-out, keeps power-down.
// [R6] Sleeping watchdog reset sets time-out and power-down.
// [R7] Power-on zeroes program counter, disables interrupts, sets stack pointer top.
// [R8] Power-on clears the watchdog counter and restarts it.
// [R9] Power-on switches every timer off.
// [R10] Power-on loads port direction to all ones, making pins inputs.
// [R11] Full resets load watchdog control 0x53 and level select 0x55; sleep keeps them.
// [R12] Cause resolves to one selector: power-on over brown-out over watchdog.
// [R13] Bad watchdog enable code resets after 2 to 3 slow oscillator cycles.
// [R14] Bad level select resets, restores its initial value, sets its flag.
module rcs_reset_seq
  import rcs_pkg::*;
#(
  parameter int DIR_W = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_power_on,
  input wire logic i_brownout,
  input wire logic i_wdt_expire,
  input wire logic i_low_speed_internal_osc,
  input wire logic i_sleeping,
  input wire logic i_halt,
  input wire logic i_clr_wdt,
  output logic o_pc_sp_clear,
  output logic o_core_init,
  output logic o_wdt_restart,
  output logic o_timeout_flag,
  output logic o_powerdown_flag,
  output logic o_wdt_enabled,
  output logic [7:0] o_watchdog_control,
  output logic [7:0] o_brownout_level_select,
  output logic [DIR_W-1:0] o_port_a_direction,
  output logic [4:0] o_cause,
  output logic o_irq
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic lvl_code_ok(input logic [7:0] v);
    lvl_code_ok = (v == RCS_LVL_CODE_0) || (v == RCS_LVL_CODE_1) ||
                  (v == RCS_LVL_CODE_2) || (v == RCS_LVL_CODE_3);
  endfunction

  function automatic logic wen_code_ok(input logic [7:0] v);
    wen_code_ok = (v[RCS_WEN_MSB:RCS_WEN_LSB] == RCS_WEN_ENABLE) ||
                  (v[RCS_WEN_MSB:RCS_WEN_LSB] == RCS_WEN_DISABLE);
  endfunction

  // ****************************************
  // Pin inputs and edge detection
  // ****************************************
  logic [3:0] pin_lvl;
  logic [3:0] pin_prev_reg;
  logic [3:0] pin_prev_next;
  logic [3:0] pin_rise;

  rcs_sync3 #(.WIDTH(4)) u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async({i_low_speed_internal_osc, i_wdt_expire, i_brownout, i_power_on}),
    .o_level(pin_lvl)
  );

  always_comb begin
    pin_prev_next = pin_lvl;
    pin_rise = pin_lvl & ~pin_prev_reg;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_prev_reg <= '0;
    end else begin
      pin_prev_reg <= pin_prev_next;
    end
  end

  // ****************************************
  // Invalid code watch on the slow oscillator
  // ****************************************
  logic [7:0] wctl_reg;
  logic [7:0] lvl_reg;
  logic [1:0] low_speed_internal_osc_cnt_reg;
  logic [1:0] low_speed_internal_osc_cnt_next;
  logic wen_bad;
  logic lvl_bad;
  logic sw_evt;

  always_comb begin
    wen_bad = !wen_code_ok(wctl_reg);
    lvl_bad = !lvl_code_ok(lvl_reg);
    low_speed_internal_osc_cnt_next = low_speed_internal_osc_cnt_reg;
    sw_evt = 1'b0;
    if (!(wen_bad || lvl_bad)) begin
      low_speed_internal_osc_cnt_next = '0;
    end else if (pin_rise[3]) begin
      if (low_speed_internal_osc_cnt_reg == RCS_SW_RST_LOW_SPEED_INTERNAL_OSC_CYC) begin
        sw_evt = 1'b1; // R13 R14
        low_speed_internal_osc_cnt_next = '0;
      end else begin
        low_speed_internal_osc_cnt_next = low_speed_internal_osc_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_speed_internal_osc_cnt_reg <= '0;
    end else begin
      low_speed_internal_osc_cnt_reg <= low_speed_internal_osc_cnt_next;
    end
  end

  // ****************************************
  // Cause selector
  // ****************************************
  rcs_cause_t cause;

  always_comb begin
    if (pin_rise[0]) begin
      cause = RCS_CAUSE_POR; // R12
    end else if (pin_rise[1] || sw_evt) begin
      cause = RCS_CAUSE_BROWNOUT; // R12
    end else if (pin_rise[2]) begin
      cause = i_sleeping ? RCS_CAUSE_WDT_SLEEP : RCS_CAUSE_WDT_RUN; // R12
    end else begin
      cause = RCS_CAUSE_NONE;
    end
  end

  // ****************************************
  // Bus slave: one wait state on every access
  // ****************************************
  logic dph_reg;
  logic dph_next;
  logic ack_reg;
  logic ack_next;
  logic wr_reg;
  logic wr_next;
  logic [7:0] addr_reg;
  logic [7:0] addr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic take;
  logic do_wr;

  always_comb begin
    take = i_hsel && i_htrans[1] && i_hready;
    dph_next = dph_reg;
    ack_next = 1'b0;
    wr_next = wr_reg;
    addr_next = addr_reg;
    if (dph_reg && !ack_reg) begin
      ack_next = 1'b1;
    end else if (take) begin
      dph_next = 1'b1;
      wr_next = i_hwrite;
      addr_next = i_haddr[7:0];
    end else if (ack_reg) begin
      dph_next = 1'b0;
    end
    do_wr = dph_reg && !ack_reg && wr_reg;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dph_reg <= 1'b0;
      ack_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= '0;
      rdata_reg <= '0;
    end else begin
      dph_reg <= dph_next;
      ack_reg <= ack_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************
  // Control, flags and initial values
  // ****************************************
  logic [7:0] wctl_next;
  logic [7:0] lvl_next;
  logic [DIR_W-1:0] dir_reg;
  logic [DIR_W-1:0] dir_next;
  logic to_reg;
  logic to_next;
  logic pd_reg;
  logic pd_next;
  logic [RCS_NUM_FLAGS-1:0] fl_reg;
  logic [RCS_NUM_FLAGS-1:0] fl_next;
  logic [4:0] cause_reg;
  logic [4:0] cause_next;
  logic [RCS_NUM_EVENTS-1:0] ist_reg;
  logic [RCS_NUM_EVENTS-1:0] ist_next;
  logic [RCS_NUM_EVENTS-1:0] ien_reg;
  logic [RCS_NUM_EVENTS-1:0] ien_next;
  logic [RCS_NUM_EVENTS-1:0] ev;
  logic pcsp_reg;
  logic pcsp_next;
  logic init_reg;
  logic init_next;
  logic wrst_reg;
  logic wrst_next;
  logic full_rst;

  always_comb begin
    wctl_next = wctl_reg;
    lvl_next = lvl_reg;
    dir_next = dir_reg;
    to_next = to_reg;
    pd_next = pd_reg;
    fl_next = fl_reg;
    ien_next = ien_reg;
    ist_next = ist_reg;
    cause_next = cause_reg;
    // Software writes first so that any full reset below overrides those to control, level select and direction
    if (do_wr) begin
      if (addr_reg == RCS_OFF_WDT_CTRL) begin
        wctl_next = i_hwdata[7:0];
      end else if (addr_reg == RCS_OFF_LVL_SEL) begin
        lvl_next = i_hwdata[7:0];
      end else if (addr_reg == RCS_OFF_PORT_DIR) begin
        dir_next = i_hwdata[DIR_W-1:0];
      end else if (addr_reg == RCS_OFF_RST_FLAGS) begin
        // Flags clear only where a zero is written
        fl_next = fl_reg & i_hwdata[RCS_NUM_FLAGS-1:0];
      end else if (addr_reg == RCS_OFF_IRQ_CLR) begin
        ist_next = ist_reg & ~i_hwdata[RCS_NUM_EVENTS-1:0];
      end else if (addr_reg == RCS_OFF_IRQ_EN) begin
        ien_next = i_hwdata[RCS_NUM_EVENTS-1:0];
      end
    end
    if (i_clr_wdt) begin
      to_next = 1'b0;
      pd_next = 1'b0;
    end
    if (i_halt) begin
      pd_next = 1'b1;
    end
    full_rst = (cause == RCS_CAUSE_POR) || (cause == RCS_CAUSE_BROWNOUT) ||
               (cause == RCS_CAUSE_WDT_RUN);
    pcsp_next = (cause != RCS_CAUSE_NONE); // R2 R7
    init_next = full_rst; // R1 R7 R9
    wrst_next = full_rst; // R8
    if (cause != RCS_CAUSE_NONE) begin
      cause_next = cause;
    end
    if (full_rst) begin
      wctl_next = RCS_WDT_CTRL_INIT; // R11
      lvl_next = RCS_LVL_SEL_INIT; // R11 R14
      dir_next = {DIR_W{1'b1}}; // R10
    end
    case (cause)
      RCS_CAUSE_POR: begin
        to_next = 1'b0; // R3
        pd_next = 1'b0; // R3
      end
      RCS_CAUSE_BROWNOUT: begin
        to_next = to_reg; // R4
        pd_next = pd_reg; // R4
      end
      RCS_CAUSE_WDT_RUN: begin
        to_next = 1'b1; // R1 R5
        pd_next = pd_reg; // R5
      end
      RCS_CAUSE_WDT_SLEEP: begin
        to_next = 1'b1; // R2 R6
        pd_next = 1'b1; // R6
      end
      default: begin
      end
    endcase
    // Hardware sets win over a software clear in the same cycle
    if (sw_evt && wen_bad) begin
      fl_next[RCS_FL_WDT_SW] = 1'b1;
    end
    if (sw_evt && lvl_bad) begin
      fl_next[RCS_FL_LVL_SW] = 1'b1; // R14
    end
    if (cause == RCS_CAUSE_BROWNOUT && pin_rise[1]) begin
      fl_next[RCS_FL_BROWNOUT] = 1'b1;
    end
    ev = '0;
    ev[RCS_EV_POR] = (cause == RCS_CAUSE_POR);
    ev[RCS_EV_BROWNOUT] = (cause == RCS_CAUSE_BROWNOUT) && pin_rise[1];
    ev[RCS_EV_WDT_RUN] = (cause == RCS_CAUSE_WDT_RUN);
    ev[RCS_EV_WDT_SLEEP] = (cause == RCS_CAUSE_WDT_SLEEP);
    ev[RCS_EV_SW_RESET] = (cause == RCS_CAUSE_BROWNOUT) && sw_evt;
    ist_next = ist_next | ev;
  end

  // Power-up values match the power-on selection above
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wctl_reg <= RCS_WDT_CTRL_INIT; // R11
      lvl_reg <= RCS_LVL_SEL_INIT; // R11
      dir_reg <= {DIR_W{1'b1}}; // R10
      to_reg <= 1'b0; // R3
      pd_reg <= 1'b0; // R3
      fl_reg <= '0;
      ien_reg <= '0;
      ist_reg <= '0;
      cause_reg <= RCS_CAUSE_POR;
      pcsp_reg <= 1'b0;
      init_reg <= 1'b0;
      wrst_reg <= 1'b0;
    end else begin
      wctl_reg <= wctl_next;
      lvl_reg <= lvl_next;
      dir_reg <= dir_next;
      to_reg <= to_next;
      pd_reg <= pd_next;
      fl_reg <= fl_next;
      ien_reg <= ien_next;
      ist_reg <= ist_next;
      cause_reg <= cause_next;
      pcsp_reg <= pcsp_next;
      init_reg <= init_next;
      wrst_reg <= wrst_next;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    rdata_next = rdata_reg;
    if (dph_reg && !ack_reg && !wr_reg) begin
      rdata_next = '0;
      if (addr_reg == RCS_OFF_STATUS) begin
        rdata_next[RCS_ST_TIMEOUT] = to_reg;
        rdata_next[RCS_ST_POWERDOWN] = pd_reg;
      end else if (addr_reg == RCS_OFF_WDT_CTRL) begin
        rdata_next[7:0] = wctl_reg;
      end else if (addr_reg == RCS_OFF_LVL_SEL) begin
        rdata_next[7:0] = lvl_reg;
      end else if (addr_reg == RCS_OFF_PORT_DIR) begin
        rdata_next[DIR_W-1:0] = dir_reg;
      end else if (addr_reg == RCS_OFF_RST_FLAGS) begin
        rdata_next[RCS_NUM_FLAGS-1:0] = fl_reg;
      end else if (addr_reg == RCS_OFF_CAUSE) begin
        rdata_next[4:0] = cause_reg;
      end else if (addr_reg == RCS_OFF_IRQ_STAT) begin
        rdata_next[RCS_NUM_EVENTS-1:0] = ist_reg;
      end else if (addr_reg == RCS_OFF_IRQ_EN) begin
        rdata_next[RCS_NUM_EVENTS-1:0] = ien_reg;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_hreadyout = !(dph_reg && !ack_reg);
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata_reg;
  assign o_pc_sp_clear = pcsp_reg;
  assign o_core_init = init_reg;
  assign o_wdt_restart = wrst_reg;
  assign o_timeout_flag = to_reg;
  assign o_powerdown_flag = pd_reg;
  assign o_wdt_enabled = (wctl_reg[RCS_WEN_MSB:RCS_WEN_LSB] == RCS_WEN_ENABLE);
  assign o_watchdog_control = wctl_reg;
  assign o_brownout_level_select = lvl_reg;
  assign o_port_a_direction = dir_reg;
  assign o_cause = cause_reg;
  assign o_irq = |(ist_reg & ien_reg);

endmodule // rcs_reset_seq
`default_nettype wire

/* sim/rcs_reset_seq_chk.sv */
// Port-level assertions for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_seq_chk
  import rcs_pkg::*;
#(
  parameter int DIR_W = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_pc_sp_clear,
  input wire logic o_core_init,
  input wire logic o_wdt_restart,
  input wire logic o_timeout_flag,
  input wire logic o_powerdown_flag,
  input wire logic o_wdt_enabled,
  input wire logic [7:0] o_watchdog_control,
  input wire logic [7:0] o_brownout_level_select,
  input wire logic [DIR_W-1:0] o_port_a_direction,
  input wire logic [4:0] o_cause
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_bus_wait: assert property (
    i_hsel && i_htrans[1] && i_hready |=> !o_hreadyout ##1 o_hreadyout) else $error("bus wait");
  a_resp_okay: assert property (!o_hresp) else $error("bus error response");
  a_init_pair: assert property (
    o_core_init |-> o_pc_sp_clear && o_wdt_restart) else $error("init pulses apart");
  a_init_vals: assert property (
    o_core_init |-> o_watchdog_control == RCS_WDT_CTRL_INIT &&
    o_brownout_level_select == RCS_LVL_SEL_INIT && &o_port_a_direction) else $error("init");
  a_pulse_one: assert property ($rose(o_pc_sp_clear) |=> !o_pc_sp_clear) else $error("pulse");
  a_por_clear: assert property (
    o_core_init && o_cause == RCS_CAUSE_POR |-> !o_timeout_flag && !o_powerdown_flag)
    else $error("power-on flags");
  a_brown_keep: assert property (
    o_core_init && o_cause == RCS_CAUSE_BROWNOUT |-> $stable(o_timeout_flag) &&
    $stable(o_powerdown_flag)) else $error("brown-out flags");
  a_run_timeout: assert property (
    o_core_init && o_cause == RCS_CAUSE_WDT_RUN |-> o_timeout_flag && $stable(o_powerdown_flag))
    else $error("running watchdog flags");
  a_sleep_flags: assert property (
    o_pc_sp_clear && !o_core_init |-> o_timeout_flag && o_powerdown_flag &&
    o_cause == RCS_CAUSE_WDT_SLEEP && !o_wdt_restart) else $error("sleep watchdog");
  a_sleep_keep: assert property (
    o_pc_sp_clear && !o_core_init |-> $stable(o_watchdog_control) &&
    $stable(o_brownout_level_select) && $stable(o_port_a_direction)) else $error("sleep kept");
  a_wen_map: assert property (
    o_wdt_enabled == (o_watchdog_control[RCS_WEN_MSB:RCS_WEN_LSB] == RCS_WEN_ENABLE))
    else $error("enable decode");
endmodule // rcs_reset_seq_chk
bind rcs_reset_seq rcs_reset_seq_chk #(.DIR_W(DIR_W)) u_chk (.i_mclk, .i_rst_n, .i_hsel,
  .i_htrans, .i_hready, .o_hreadyout, .o_hresp, .o_pc_sp_clear, .o_core_init, .o_wdt_restart,
  .o_timeout_flag, .o_powerdown_flag, .o_wdt_enabled, .o_watchdog_control,
  .o_brownout_level_select, .o_port_a_direction, .o_cause);
`default_nettype wire

/* sim/rcs_core_model.sv */
// Core and slow oscillator model facing the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module rcs_core_model (
  input wire logic i_mclk,
  input wire logic [1:0] i_cmd,
  input wire logic i_pc_sp_clear,
  output logic o_low_speed_internal_osc,
  output logic o_sleeping,
  output logic o_halt,
  output logic o_clr_wdt
);
  logic [3:0] div_reg;
  initial begin
    div_reg = 4'h0;
    o_low_speed_internal_osc = 1'b0;
    o_sleeping = 1'b0;
    o_halt = 1'b0;
    o_clr_wdt = 1'b0;
  end
  // Slow clock free-runs at 1/32 of the main clock, so code checks take tens of cycles
  always @(posedge i_mclk) begin
    div_reg <= div_reg + 4'h1;
    if (div_reg == 4'hf) begin
      o_low_speed_internal_osc <= !o_low_speed_internal_osc;
    end
    o_halt <= i_cmd == 2'h1;
    o_clr_wdt <= i_cmd == 2'h2;
    // Any reset pulse wakes a halted core
    if (i_cmd == 2'h1) begin
      o_sleeping <= 1'b1;
    end else if (i_pc_sp_clear) begin
      o_sleeping <= 1'b0;
    end
  end
endmodule // rcs_core_model
`default_nettype wire

/* sim/rcs_reset_seq_test.sv */
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_seq_test;
  import rcs_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwr = 1'b0, rd_ph = 1'b0;
  logic [1:0] htr = 2'h0, cmd = 2'h0;
  logic [2:0] pins = 3'h0;
  logic [31:0] ha = 32'h0, hwd = 32'h0, hrd;
  logic rdy, low_speed_internal_osc, slp, halt, clrw, pcs, cini, wrs, wen, irq, tof, powerdown_flag;
  logic [7:0] pdir;
  logic [4:0] cause;
  logic [31:0] rq[$], eq[$];
  int fail_count = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  rcs_reset_seq dut (.i_mclk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(ha),
    .i_htrans(htr), .i_hwrite(hwr), .i_hsize(3'h2), .i_hwdata(hwd), .i_hready(rdy),
    .o_hreadyout(rdy), .o_hresp(), .o_hrdata(hrd), .i_power_on(pins[0]),
    .i_brownout(pins[1]), .i_wdt_expire(pins[2]), .i_low_speed_internal_osc(low_speed_internal_osc), .i_sleeping(slp),
    .i_halt(halt), .i_clr_wdt(clrw), .o_pc_sp_clear(pcs), .o_core_init(cini),
    .o_wdt_restart(wrs), .o_timeout_flag(tof), .o_powerdown_flag(powerdown_flag), .o_wdt_enabled(wen),
    .o_watchdog_control(), .o_brownout_level_select(), .o_port_a_direction(pdir),
    .o_cause(cause), .o_irq(irq));
  rcs_core_model core (.i_mclk(clk), .i_cmd(cmd), .i_pc_sp_clear(pcs), .o_low_speed_internal_osc(low_speed_internal_osc),
    .o_sleeping(slp), .o_halt(halt), .o_clr_wdt(clrw));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic final_report;
    $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic hang;
    fail_count++;
    $display("FAIL %0t: wait ran out", $time);
    final_report;
  endtask
  // Ready is looked at mid-cycle, where it is settled for the next edge
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (rdy !== 1'b1 && k < 50);
    @(posedge clk);
    if (k >= 50) hang;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htr <= 2'h2;
    hwr <= w;
    ha <= {24'h0, a};
    wait_rdy;
    hsel <= 1'b0;
    htr <= 2'h0;
    hwd <= d;
    wait_rdy;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Expected {core init, restart, cause}; a zero cause is not compared
  task automatic ev(input logic [2:0] p, input logic [6:0] e);
    int k;
    eq.push_back({25'h0, e});
    @(posedge clk);
    pins <= p;
    k = 0;
    while (eq.size() != 0 && k < 300) begin
      @(posedge clk);
      k++;
    end
    pins <= 3'h0;
    if (k >= 300) hang;
  endtask
  task automatic core_cmd(input logic [1:0] c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= 2'h0;
    repeat (2) @(posedge clk);
  endtask
  always @(posedge clk) begin : mon
    logic [31:0] e;
    if (pcs === 1'b1) begin
      e = eq.size() != 0 ? eq.pop_front() : 32'hdead;
      chk({25'h0, cini, wrs, e[4:0] == 5'h0 ? 5'h0 : cause}, e);
    end
    if (rd_ph && rdy) begin
      rd_ph = 1'b0;
      chk(hrd, rq.pop_front());
    end
    if (hsel && htr[1] && rdy) rd_ph = !hwr;
  end
  initial begin
    logic [31:0] dv;
    dv = $urandom(34413);
    dv = $urandom;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(RCS_OFF_STATUS, 32'h0);
    rd(RCS_OFF_WDT_CTRL, 32'h53);
    rd(RCS_OFF_LVL_SEL, 32'h55);
    rd(RCS_OFF_PORT_DIR, 32'hff);
    chk(wen, 32'h1);
    bus(1'b1, RCS_OFF_PORT_DIR, dv);
    rd(RCS_OFF_PORT_DIR, {24'h0, dv[7:0]});
    bus(1'b1, RCS_OFF_STATUS, 32'h3);
    rd(RCS_OFF_STATUS, 32'h0);
    rd(8'h40, 32'h0);
    $display("Test reset and registers done");
    bus(1'b1, RCS_OFF_IRQ_EN, 32'h1f);
    bus(1'b1, RCS_OFF_WDT_CTRL, 32'hab);
    chk(wen, 32'h0);
    bus(1'b1, RCS_OFF_LVL_SEL, 32'h33);
    ev(3'h4, {2'b11, RCS_CAUSE_WDT_RUN});
    rd(RCS_OFF_STATUS, 32'h1);
    chk({30'h0, tof, powerdown_flag}, 32'h2);
    rd(RCS_OFF_WDT_CTRL, 32'h53);
    rd(RCS_OFF_LVL_SEL, 32'h55);
    rd(RCS_OFF_PORT_DIR, 32'hff);
    chk({24'h0, pdir}, 32'hff);
    core_cmd(2'h1);
    rd(RCS_OFF_STATUS, 32'h3);
    ev(3'h2, {2'b11, RCS_CAUSE_BROWNOUT});
    rd(RCS_OFF_STATUS, 32'h3);
    $display("Test running resets done");
    core_cmd(2'h2);
    rd(RCS_OFF_STATUS, 32'h0);
    core_cmd(2'h1);
    bus(1'b1, RCS_OFF_LVL_SEL, 32'h99);
    bus(1'b1, RCS_OFF_PORT_DIR, dv);
    ev(3'h4, {2'b00, RCS_CAUSE_WDT_SLEEP});
    rd(RCS_OFF_STATUS, 32'h3);
    rd(RCS_OFF_LVL_SEL, 32'h99);
    rd(RCS_OFF_PORT_DIR, {24'h0, dv[7:0]});
    rd(RCS_OFF_IRQ_STAT, 32'he);
    chk(irq, 32'h1);
    bus(1'b1, RCS_OFF_IRQ_EN, 32'h0);
    chk(irq, 32'h0);
    bus(1'b1, RCS_OFF_IRQ_EN, 32'h1f);
    bus(1'b1, RCS_OFF_IRQ_CLR, 32'h1f);
    rd(RCS_OFF_IRQ_STAT, 32'h0);
    chk(irq, 32'h0);
    $display("Test sleep and interrupt done");
    ev(3'h7, {2'b11, RCS_CAUSE_POR});
    rd(RCS_OFF_STATUS, 32'h0);
    bus(1'b1, RCS_OFF_RST_FLAGS, 32'h0);
    bus(1'b1, RCS_OFF_WDT_CTRL, 32'h3);
    ev(3'h0, 7'h60);
    rd(RCS_OFF_WDT_CTRL, 32'h53);
    rd(RCS_OFF_RST_FLAGS, 32'h1);
    bus(1'b1, RCS_OFF_LVL_SEL, 32'h12);
    ev(3'h0, 7'h60);
    rd(RCS_OFF_LVL_SEL, 32'h55);
    rd(RCS_OFF_RST_FLAGS, 32'h3);
    $display("Test priority and bad codes done");
    final_report;
  end
endmodule // rcs_reset_seq_test
`default_nettype wire
